// ### lcdc_pkg.sv
// Constants and types shared by the LCD display mode and clock control block
package lcdc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register addresses
    localparam logic [ADDR_W-1:0] DISPLAY_MODE_ADDR = 16'hFFB0;
    localparam logic [ADDR_W-1:0] SCAN_CLOCK_ADDR = 16'hFFB2;

    // Reset values and implemented bits
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MODE_WR_MASK = 8'hD4;
    localparam logic [DATA_W-1:0] CLOCK_WR_MASK = 8'h0F;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // Display mode register fields
    localparam int DISPLAY_ON_POS = 7;
    localparam int BOOSTER_ON_POS = 6;
    localparam int PIN_DRIVE_POS = 4;
    localparam int STATIC_SEL_POS = 2;

    // Scan clock register fields
    localparam int SEL_W = 2;
    localparam int SOURCE_SEL_LSB = 2;
    localparam int SCAN_DIV_LSB = 0;
    localparam logic [SEL_W-1:0] SRC_SUBSYSTEM = 2'h0;
    localparam logic [SEL_W-1:0] SRC_MAIN_OFFSET = 2'h1;

    // Dividers: main clock / 2^5..2^7, source clock / 2^6..2^9
    localparam int MAIN_DIV_BASE = 5;
    localparam int MAIN_DIV_W = 7;
    localparam int SCAN_DIV_BASE = 6;
    localparam int SCAN_DIV_W = 9;

    // Time slices per frame
    localparam int SLICE_W = 2;
    localparam logic [SLICE_W-1:0] SLICE_FIRST = 2'h0;
    localparam logic [SLICE_W-1:0] SLICE_LAST = 2'h3;
    localparam logic [SLICE_W-1:0] SLICE_STEP = 2'h1;

    typedef enum logic [2:0] {
        PS_GROUND = 3'b001,
        PS_BLANK = 3'b010,
        PS_SHOW = 3'b100
    } lcdc_pin_state_type;

    typedef enum logic [2:0] {
        SEG_GROUND = 3'b001,
        SEG_UNSELECTED = 3'b010,
        SEG_DATA = 3'b100
    } lcdc_seg_level_type;

    typedef enum logic [1:0] {
        COM_GROUND = 2'b01,
        COM_WAVE = 2'b10
    } lcdc_com_level_type;
endpackage

// ### lcdc_div.sv
// Power-of-two divider with a selectable tap, producing one-cycle ticks
`timescale 1ns/1ps
module lcdc_div #(
    parameter int CNT_W = 9,
    parameter int BASE = 6,
    parameter int SEL_W = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Control
    input wire logic clear_in,
    input wire logic enable_in,
    input wire logic [SEL_W-1:0] sel_in,
    // Result
    output logic tick_out
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;
    logic tick_r;

    // Low BASE+sel bits form the active divider
    genvar gi;
    generate
        for (gi = 0; gi < CNT_W; gi++) begin : g_mask
            assign mask[gi] = (gi < (BASE + int'(sel_in)));
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= '0;
        end else if (clear_in) begin
            cnt_r <= '0;
        end else if (enable_in) begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= !clear_in && enable_in && ((cnt_r & mask) == mask);
        end
    end

    assign tick_out = tick_r;
endmodule

// ### lcdc_top.sv
// LCD display mode and clock control: registers, clock dividers, slice timing, pin drive
`timescale 1ns/1ps
module lcdc_top
    import lcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // CPU register access
    input wire logic [lcdc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [lcdc_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [lcdc_pkg::DATA_W-1:0] rdata_out,
    // Subsystem oscillator
    input wire logic subclk_in,
    // Analog and pin control
    output logic display_on_out,
    output logic booster_on_out,
    output logic pin_drive_on_out,
    output logic static_mode_out,
    output lcdc_pkg::lcdc_seg_level_type seg_level_out,
    output lcdc_pkg::lcdc_com_level_type com_level_out,
    // Scan timing
    output logic [lcdc_pkg::SLICE_W-1:0] slice_out,
    output logic scan_tick_out,
    output logic frame_tick_out
);
    import lcdc_pkg::*;

    logic [DATA_W-1:0] display_mode_reg_r;
    logic [DATA_W-1:0] scan_clock_reg_r;
    logic [DATA_W-1:0] rdata_r;
    logic mode_sel;
    logic clock_sel;
    logic mode_wr;
    logic clock_wr;
    logic [SEL_W-1:0] active_source_r;
    logic [SEL_W-1:0] active_scan_div_r;
    logic sub_meta_r;
    logic sub_sync_r;
    logic sub_prev_r;
    logic sub_rise;
    logic main_tick;
    logic source_tick;
    logic scan_tick;
    logic [SEL_W-1:0] main_sel;
    logic display_on_bit;
    logic booster_on_bit;
    logic pin_drive_on_bit;
    logic static_select_bit;
    logic clocks_idle;
    logic timing_clear;
    logic [SLICE_W-1:0] slice_r;
    logic [SLICE_W-1:0] slice_nxt;
    logic frame_tick_r;
    lcdc_pin_state_type pin_state_r;
    lcdc_pin_state_type pin_state_nxt;
    lcdc_seg_level_type seg_level_r;
    lcdc_com_level_type com_level_r;

    assign display_on_bit = display_mode_reg_r[DISPLAY_ON_POS];
    assign booster_on_bit = display_mode_reg_r[BOOSTER_ON_POS];
    assign pin_drive_on_bit = display_mode_reg_r[PIN_DRIVE_POS];
    assign static_select_bit = display_mode_reg_r[STATIC_SEL_POS];

    // Address decode shared by write and read paths
    assign mode_sel = (addr_in == DISPLAY_MODE_ADDR);
    assign clock_sel = (addr_in == SCAN_CLOCK_ADDR);
    assign mode_wr = wr_in && mode_sel;
    assign clock_wr = wr_in && clock_sel;

    // Register writes; unimplemented bits are not stored and read back zero
    // Prohibited enable combinations are stored as written; software keeps them out
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            display_mode_reg_r <= REG_RESET;
        end else if (mode_wr) begin
            display_mode_reg_r <= wdata_in & MODE_WR_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scan_clock_reg_r <= REG_RESET;
        end else if (clock_wr) begin
            scan_clock_reg_r <= wdata_in & CLOCK_WR_MASK;
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_r <= UNMAPPED_READ;
        end else if (rd_in) begin
            if (mode_sel) begin
                rdata_r <= display_mode_reg_r;
            end else if (clock_sel) begin
                rdata_r <= scan_clock_reg_r;
            end else begin
                rdata_r <= UNMAPPED_READ;
            end
        end
    end

    // Clock selection copied only while display and booster are both off,
    // so a careless rewrite cannot glitch a running frame
    assign clocks_idle = !display_on_bit && !booster_on_bit;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            active_source_r <= SRC_SUBSYSTEM;
        end else if (clocks_idle) begin
            active_source_r <= scan_clock_reg_r[SOURCE_SEL_LSB +: SEL_W];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            active_scan_div_r <= '0;
        end else if (clocks_idle) begin
            active_scan_div_r <= scan_clock_reg_r[SCAN_DIV_LSB +: SEL_W];
        end
    end

    // Subsystem oscillator is asynchronous: two flops, then edge detect
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sub_meta_r <= 1'b0;
            sub_sync_r <= 1'b0;
        end else begin
            sub_meta_r <= subclk_in;
            sub_sync_r <= sub_meta_r;
        end
    end

    // Edge detect reads the synchronised copy only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sub_prev_r <= 1'b0;
        end else begin
            sub_prev_r <= sub_sync_r;
        end
    end

    assign sub_rise = sub_sync_r && !sub_prev_r;

    // Codes 1..3 map to taps 2^5..2^7 of the main prescaler
    assign main_sel = active_source_r - SRC_MAIN_OFFSET;

    // Frame timing restarts from zero at every display enable
    assign timing_clear = !display_on_bit;

    lcdc_div #(
        .CNT_W(MAIN_DIV_W),
        .BASE(MAIN_DIV_BASE),
        .SEL_W(SEL_W)
    ) u_main_div (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .clear_in(timing_clear),
        .enable_in(1'b1),
        .sel_in(main_sel),
        .tick_out(main_tick)
    );

    // Source clock enable: subsystem edge or main clock division
    assign source_tick = (active_source_r == SRC_SUBSYSTEM) ? sub_rise : main_tick;

    lcdc_div #(
        .CNT_W(SCAN_DIV_W),
        .BASE(SCAN_DIV_BASE),
        .SEL_W(SEL_W)
    ) u_scan_div (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .clear_in(timing_clear),
        .enable_in(source_tick),
        .sel_in(active_scan_div_r),
        .tick_out(scan_tick)
    );

    // Slice counter: four slices per frame, a single one in static mode
    always_comb begin
        slice_nxt = slice_r;
        if (timing_clear) begin
            slice_nxt = SLICE_FIRST;
        end else if (scan_tick) begin
            if (static_select_bit || (slice_r == SLICE_LAST)) begin
                slice_nxt = SLICE_FIRST;
            end else begin
                slice_nxt = slice_r + SLICE_STEP;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slice_r <= SLICE_FIRST;
        end else begin
            slice_r <= slice_nxt;
        end
    end

    // Frame end flagged one cycle after the closing scan tick
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_tick_r <= 1'b0;
        end else begin
            frame_tick_r <= !timing_clear && scan_tick
                && (static_select_bit || (slice_r == SLICE_LAST));
        end
    end

    // Pin drive state follows pin control and display enable
    // Pin drive off wins over display enable: grounded pins show nothing
    always_comb begin
        if (!pin_drive_on_bit) begin
            pin_state_nxt = PS_GROUND;
        end else if (!display_on_bit) begin
            pin_state_nxt = PS_BLANK;
        end else begin
            pin_state_nxt = PS_SHOW;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_state_r <= PS_GROUND;
        end else begin
            pin_state_r <= pin_state_nxt;
        end
    end

    // Registered pin levels, decoded from the next state so they move with it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seg_level_r <= SEG_GROUND;
        end else begin
            unique case (pin_state_nxt)
                PS_GROUND: begin
                    seg_level_r <= SEG_GROUND;
                end
                PS_BLANK: begin
                    seg_level_r <= SEG_UNSELECTED;
                end
                PS_SHOW: begin
                    seg_level_r <= SEG_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            com_level_r <= COM_GROUND;
        end else begin
            unique case (pin_state_nxt)
                PS_GROUND: begin
                    com_level_r <= COM_GROUND;
                end
                PS_BLANK: begin
                    com_level_r <= COM_WAVE;
                end
                PS_SHOW: begin
                    com_level_r <= COM_WAVE;
                end
            endcase
        end
    end

    assign rdata_out = rdata_r;
    assign display_on_out = display_on_bit;
    assign booster_on_out = booster_on_bit;
    assign pin_drive_on_out = pin_drive_on_bit;
    assign static_mode_out = static_select_bit;
    assign seg_level_out = seg_level_r;
    assign com_level_out = com_level_r;
    assign slice_out = slice_r;
    assign scan_tick_out = scan_tick;
    assign frame_tick_out = frame_tick_r;
endmodule

// ### lcdc_props.sv
// Port-level assertions for the LCD mode and clock control block
`timescale 1ns/1ps
module lcdc_props
    import lcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Register access
    input wire logic [lcdc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [lcdc_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [lcdc_pkg::DATA_W-1:0] rdata_out,
    // Control and timing
    input wire logic display_on_out,
    input wire logic booster_on_out,
    input wire logic pin_drive_on_out,
    input wire logic static_mode_out,
    input wire lcdc_pkg::lcdc_seg_level_type seg_level_out,
    input wire lcdc_pkg::lcdc_com_level_type com_level_out,
    input wire logic [lcdc_pkg::SLICE_W-1:0] slice_out,
    input wire logic scan_tick_out,
    input wire logic frame_tick_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_wrm; wr_in && addr_in == DISPLAY_MODE_ADDR; endsequence
    sequence s_rdm; rd_in && addr_in == DISPLAY_MODE_ADDR; endsequence
    sequence s_rdc; rd_in && addr_in == SCAN_CLOCK_ADDR; endsequence
    sequence s_rdx; rd_in && addr_in != DISPLAY_MODE_ADDR && addr_in != SCAN_CLOCK_ADDR; endsequence
    // Three idle cycles let a tick already in flight drain
    sequence s_off3; !display_on_out [*3]; endsequence
    property p_mode_wr;
        s_wrm |=> {display_on_out, booster_on_out, pin_drive_on_out, static_mode_out} ==
            $past({wdata_in[7], wdata_in[6], wdata_in[4], wdata_in[2]});
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode outputs wrong");
    property p_mode_rd;
        s_rdm |=> rdata_out == $past({display_on_out, booster_on_out, 1'b0, pin_drive_on_out,
            1'b0, static_mode_out, 2'b00});
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read wrong");
    property p_clk_rd; s_rdc |=> rdata_out[7:4] == 4'h0; endproperty
    a_clk_rd: assert property (p_clk_rd) else $error("clock read wrong");
    property p_unmapped; s_rdx |=> rdata_out == UNMAPPED_READ; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
    property p_ground; !pin_drive_on_out |=> seg_level_out == SEG_GROUND && com_level_out == COM_GROUND; endproperty
    a_ground: assert property (p_ground) else $error("pins not grounded");
    property p_blank;
        pin_drive_on_out && !display_on_out |=> seg_level_out == SEG_UNSELECTED && com_level_out == COM_WAVE;
    endproperty
    a_blank: assert property (p_blank) else $error("display off levels wrong");
    property p_show; pin_drive_on_out && display_on_out |=> seg_level_out == SEG_DATA; endproperty
    a_show: assert property (p_show) else $error("display on levels wrong");
    property p_idle; s_off3 |-> slice_out == SLICE_FIRST && !scan_tick_out && !frame_tick_out; endproperty
    a_idle: assert property (p_idle) else $error("timing runs while off");
    property p_frame; frame_tick_out |-> $past(scan_tick_out); endproperty
    a_frame: assert property (p_frame) else $error("frame tick without scan tick");
endmodule
bind lcdc_top lcdc_props lcdc_props_inst (.*);

// ### lcdc_panel.sv
// Panel model counting frames driven onto the commons
`timescale 1ns/1ps
module lcdc_panel
    import lcdc_pkg::*;
(
    // Drive from the controller
    input wire logic clk_in,
    input wire logic frame_tick_in,
    input wire lcdc_pkg::lcdc_com_level_type com_level_in,
    // Observation
    output int frames_out
);
    int count_r = 0;
    assign frames_out = count_r;
    // Grounded commons show nothing, so those frames are not seen
    always @(posedge clk_in) begin
        if (frame_tick_in && com_level_in == COM_WAVE) count_r <= count_r + 1;
    end
endmodule

// ### tb_lcdc_top.sv
// Self-checking bench for the LCD mode and clock control block
`timescale 1ns/1ps
module tb_lcdc_top;
    import lcdc_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, subclk_in = 1'b0, rd_d = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0, rdata_out, d, m;
    // Booster settle wait, scaled down from half a second to keep the run short
    localparam int SETTLE = 64;
    logic display_on_out, booster_on_out, pin_drive_on_out, static_mode_out, scan_tick_out, frame_tick_out;
    lcdc_seg_level_type seg_level_out;
    lcdc_com_level_type com_level_out;
    logic [SLICE_W-1:0] slice_out;
    logic [7:0] exp_q[$];
    int failures = 0, checked = 0, cyc = 0, frames, f0, k;

    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;
    // Subsystem clock scaled to four cycles a period; its frame rates map to 16..128 Hz
    always @(posedge clk_in) if (cyc % 2 == 1) subclk_in <= ~subclk_in;

    lcdc_top lcdc_top_inst (.*);
    lcdc_panel lcdc_panel_inst (.clk_in(clk_in), .frame_tick_in(frame_tick_out),
        .com_level_in(com_level_out), .frames_out(frames));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    always @(posedge clk_in) rd_d <= rd_in;
    always @(negedge clk_in) if (rd_d) check(rdata_out, exp_q.pop_front());
    task automatic lv(input logic [7:0] m, input logic [2:0] s, input logic [1:0] c);
        wr(DISPLAY_MODE_ADDR, m);
        @(negedge clk_in);
        check(seg_level_out, s);
        check(com_level_out, c);
    endtask
    // Shutdown order: display off, pin drive off, static on, booster off
    task automatic off();
        wr(DISPLAY_MODE_ADDR, 8'h50);
        wr(DISPLAY_MODE_ADDR, 8'h40);
        wr(DISPLAY_MODE_ADDR, 8'h44);
        wr(DISPLAY_MODE_ADDR, 8'h04);
    endtask
    // Start order from boost stopped
    task automatic on();
        wr(DISPLAY_MODE_ADDR, 8'h44);
        repeat (SETTLE) @(posedge clk_in);
        wr(DISPLAY_MODE_ADDR, 8'h40);
        wr(DISPLAY_MODE_ADDR, 8'h50);
        wr(DISPLAY_MODE_ADDR, 8'hD0);
    endtask
    task automatic wt(input bit f);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(negedge clk_in);
            if ((f ? frame_tick_out : scan_tick_out) === 1'b1) return;
        end
        failures++;
        conclude();
    endtask
    task automatic gap(input bit f, input logic [31:0] e);
        int t0;
        wt(f);
        t0 = cyc;
        wt(f);
        check(cyc - t0, e);
    endtask

    initial begin
        void'($urandom(32'hF4C7BBEA));
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(DISPLAY_MODE_ADDR, 8'h00);
        rd(SCAN_CLOCK_ADDR, 8'h00);
        rd(16'hFFB1, UNMAPPED_READ);
        @(negedge clk_in);
        check(seg_level_out, SEG_GROUND);
        $display("Test reset values done");
        wr(DISPLAY_MODE_ADDR, 8'h04);
        repeat (4) begin
            d = 8'($urandom);
            m = 8'h04 | (d & 8'h40) | ((d[6] && d[4]) ? 8'h10 : 8'h00);
            wr(SCAN_CLOCK_ADDR, d & CLOCK_WR_MASK);
            rd(SCAN_CLOCK_ADDR, d & CLOCK_WR_MASK);
            wr(DISPLAY_MODE_ADDR, m & 8'h44);
            check(booster_on_out, d[6]);
            wr(DISPLAY_MODE_ADDR, m);
            rd(DISPLAY_MODE_ADDR, m);
            wr(DISPLAY_MODE_ADDR, m & 8'h44);
            wr(DISPLAY_MODE_ADDR, 8'h04);
        end
        $display("Test register access done");
        lv(8'h44, SEG_GROUND, COM_GROUND);
        repeat (SETTLE) @(posedge clk_in);
        lv(8'h40, SEG_GROUND, COM_GROUND);
        lv(8'h50, SEG_UNSELECTED, COM_WAVE);
        lv(8'hD0, SEG_DATA, COM_WAVE);
        $display("Test pin levels done");
        for (k = 0; k < 8; k++) begin
            off();
            wr(SCAN_CLOCK_ADDR, k < 4 ? 8'(k) : k < 7 ? 8'((k - 3) << 2) : 8'h04);
            on();
            if (k < 7) gap(1'b0, k < 4 ? 256 << k : 1024 << (k - 3));
        end
        gap(1'b1, 32'd8192);
        wr(SCAN_CLOCK_ADDR, 8'h0C);
        gap(1'b0, 32'd2048);
        rd(SCAN_CLOCK_ADDR, 8'h0C);
        wr(DISPLAY_MODE_ADDR, 8'hD4);
        check(static_mode_out, 1'b1);
        f0 = frames;
        gap(1'b1, 32'd2048);
        @(negedge clk_in);
        check(frames - f0, 32'd2);
        $display("Test scan timing done");
        off();
        check(seg_level_out, SEG_GROUND);
        $display("Test shutdown done");
        conclude();
    end
endmodule
